// *** dv/owb_slave_model.sv ***
`timescale 1ns/1ps
module owb_slave_model
#(
    parameter real US = 25.0
)
(
    input wire lineLevel,
    input wire present,
    input wire bitVal,
    output logic pullLow
);
    realtime t0;
    initial pullLow = 1'b0;
    // read answer timed from the falling edge, presence answer from the rising edge
    always @(negedge lineLevel)
    begin
        t0 = $realtime;
        if (!bitVal)
        begin
            #(US) pullLow = 1'b1;
            #(29 * US) pullLow = 1'b0;
        end
        @(posedge lineLevel);
        if (present && $realtime - t0 > 400 * US)
        begin
            #(20 * US) pullLow = 1'b1;
            #(100 * US) pullLow = 1'b0;
        end
    end
endmodule

// *** dv/owb_slot_monitor.sv ***
`timescale 1ns/1ps
module owb_slot_monitor
(
    input wire core_clk,
    input wire rst_n,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire singleWirePinOut,
    input wire singleWirePinOe
);
    logic aw;
    logic [9:0] ar;
    logic [7:0] dv;
    logic [2:0] pd;
    logic [2:0] knd;
    int lc;
    int us;
    assign us = dv + 1;
    // divisor shadowed from bus writes, so slot figures scale with it
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            aw <= 1'b0;
            dv <= 8'h27;
            lc <= 0;
            knd <= 3'h0;
        end
        else
        begin
            aw <= hsel && htrans[1] && hready && hwrite;
            ar <= haddr[11:2];
            pd <= hwdata[2:0];
            if (aw && ar == 10'h2)
                dv <= hwdata[7:0];
            lc <= singleWirePinOe ? lc + 1 : 0;
            if ($rose(singleWirePinOe))
                knd <= pd;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_wz_low: assert property ($fell(singleWirePinOe) && knd[1] |->
        lc inside {[100 * us - 1 : 100 * us + 1]}) else $error("write-zero low time off");
    chk_wor_low: assert property ($fell(singleWirePinOe) && knd[2:1] == 2'h2 |->
        lc inside {[6 * us - 1 : 6 * us + 1]}) else $error("write-one low time off");
    chk_pres_low: assert property ($fell(singleWirePinOe) && knd[2:1] == 2'h0 |->
        lc inside {[480 * us - 1 : 480 * us + 1]}) else $error("presence low time off");
    chk_oe_cause: assert property ($rose(singleWirePinOe) |->
        $past(aw && ar == 10'h0) && pd != 3'h0) else $error("line pulled without command");
    chk_pin_out: assert property (singleWirePinOut == 1'b0)
        else $error("line driven high");
    chk_line_release: assert property ($fell(singleWirePinOe) |=>
        !singleWirePinOe [*8]) else $error("line pulled again too soon");
    chk_min_low: assert property ($rose(singleWirePinOe) |->
        singleWirePinOe [*5]) else $error("slot low phase too short");
    chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    cover property ($fell(singleWirePinOe) && knd[1]);
    cover property ($fell(singleWirePinOe) && knd[2:1] == 2'h2);
    cover property ($fell(singleWirePinOe) && knd == 3'h1);
endmodule
bind owb_slot_master owb_slot_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .singleWirePinOut(singleWirePinOut),
    .singleWirePinOe(singleWirePinOe));

// *** dv/tb_one_wire_bus_master_slots.sv ***
`timescale 1ns/1ps
module tb_one_wire_bus_master_slots;
    logic core_clk, rst_n, hsel, hwrite, present, bitVal;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, pinOut, pinOe, pullLow, line;
    int err_total, checked, seed, us, t0, expRd, expPres;
    int cyc = 0;
    int expQ[$];
    // pull-up on the line: low only while someone pulls
    assign line = !((pinOe && !pinOut) || pullLow);
    owb_slot_master dut_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .singleWirePinIn(line),
        .singleWirePinOut(pinOut), .singleWirePinOe(pinOe));
    owb_slave_model slv_u (.lineLevel(line), .present(present), .bitVal(bitVal),
        .pullLow(pullLow));
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            err_total = err_total + 1;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("mismatches=%0d comparisons=%0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input logic [31:0] g, input logic [31:0] e);
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checked = checked + 1;
        if (g !== e)
            fail(g, e);
    endtask
    task automatic chkLen(input int g, input int lo, input int hi);
        checked = checked + 1;
        if (g < lo || g > hi)
            fail(g, lo);
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        q = hrdata;
        chk32(hresp, 32'h0);
    endtask
    // a command written mid-slot must neither restart nor stretch it
    task automatic slot(input logic [2:0] cmd, input int totUs);
        bus(1'b1, 12'h000, {29'h0, cmd});
        t0 = cyc;
        bus(1'b0, 12'h004, 32'h0);
        chk32(q[2], 1'b1);
        bus(1'b1, 12'h000, 32'h7);
        do
            bus(1'b0, 12'h000, 32'h0);
        while (q[2:0] !== 3'h0);
        chkLen(cyc - t0, totUs * us - 1, totUs * us + 8);
        bus(1'b0, 12'h004, 32'h0);
        chk32(q, (expRd << 1) | expPres);
    endtask
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        present = 1'b1;
        bitVal = 1'b1;
        err_total = 0;
        checked = 0;
        seed = 32'hcc479c73;
        expRd = 0;
        expPres = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, 12'h008, 32'h0);
        chk32(q, 32'h27);
        bus(1'b0, 12'h004, 32'h0);
        chk32(q, 32'h0);
        bus(1'b0, 12'h00c, 32'h0);
        chk32(q, 32'h0);
        bus(1'b1, 12'h008, 32'h1);
        us = 2;
        expRd = 1;
        slot(3'h4, 70);
        bus(1'b1, 12'h008, 32'h0);
        us = 1;
        repeat (6)
        begin
            bitVal <= $random(seed);
            @(posedge core_clk);
            expQ.push_back(bitVal);
            expRd = expQ.pop_front();
            slot(3'h4, 70);
        end
        slot(3'h6, 117);
        present <= 1'b1;
        expPres = 1;
        slot(3'h1, 960);
        present <= 1'b0;
        expPres = 0;
        slot(3'h1, 960);
        complete_run;
    end
endmodule

// *** hdl/owb_slot_master.v ***
`timescale 1ns/1ps
`include "owb_consts.vh"

// Operation
// - after presence phase, flag is one if a slave answered, else zero
// - the presence flag is cleared at reset and stays cleared until a presence phase finds a slave
// - a write-zero slot lasts 117 microseconds from its start
// - write-zero slot pulls the line low for the first 100 microseconds
// - setting the write-zero command bit starts a write-zero slot
// - the write-zero command bit clears itself when the slot ends
// - write-one and read slots share one waveform and one generator
// - every write-one or read slot starts by driving the line low
// - write-one/read command bit starts the slot and self-clears at its end
// - read result bit is loaded at slot end with the sampled line value
module owb_slot_master
(
    input wire core_clk,
    input wire rst_n,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire singleWirePinIn,
    output reg singleWirePinOut,
    output reg singleWirePinOe
);

    localparam ST_IDLE = 3'b001;
    localparam ST_LOW = 3'b010;
    localparam ST_REL = 3'b100;

    localparam KIND_PRES = 2'h0;
    localparam KIND_WZ = 2'h1;
    localparam KIND_WOR = 2'h2;

    reg [2:0] state;
    reg [1:0] kind;
    reg [`OWB_TICK_W-1:0] usCount;
    reg presenceCmd;
    reg writeZeroCmd;
    reg writeOneReadCmd;
    reg presenceFlag;
    reg readResultBit;
    reg sampleVal;
    reg [`OWB_DIV_W-1:0] divisor;
    reg wrPend;
    reg rdPend;
    reg [11:0] dataAddr;
    reg startSlot;
    reg [1:0] startKind;
    wire tick;
    wire addrAccept;
    wire [`OWB_TICK_W-1:0] next_usCount;
    wire slotBusy;
    wire wrCtrl;
    wire wrDiv;
    wire lowDone;
    wire sampleHit;
    wire slotDone;
    reg [2:0] next_state;
    reg [31:0] next_rdata;

    // low-phase length for each slot kind
    function [`OWB_TICK_W-1:0] slotLow;
        input [1:0] k;
        begin
            case (k)
                KIND_WZ: slotLow = `OWB_WZ_LOW_US;
                KIND_WOR: slotLow = `OWB_WOR_LOW_US;
                default: slotLow = `OWB_PRES_LOW_US;
            endcase
        end
    endfunction

    // total slot length for each slot kind
    function [`OWB_TICK_W-1:0] slotTotal;
        input [1:0] k;
        begin
            case (k)
                KIND_WZ: slotTotal = `OWB_WZ_TOTAL_US;
                KIND_WOR: slotTotal = `OWB_WOR_TOTAL_US;
                default: slotTotal = `OWB_PRES_TOTAL_US;
            endcase
        end
    endfunction

    // instant the line is sampled; write-zero never samples
    function [`OWB_TICK_W-1:0] slotSample;
        input [1:0] k;
        begin
            case (k)
                KIND_WOR: slotSample = `OWB_WOR_SAMPLE_US;
                KIND_PRES: slotSample = `OWB_PRES_SAMPLE_US;
                default: slotSample = {`OWB_TICK_W{1'b0}};
            endcase
        end
    endfunction

    // word decode; byte lanes are ignored since only whole words move
    function regHit;
        input [11:0] a;
        input [11:0] r;
        begin
            regHit = (a[11:2] == r[11:2]);
        end
    endfunction

    // restart aligns the microsecond grid to the slot's falling edge
    owb_tick_gen u_tick
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(startSlot),
        .divisor(divisor),
        .tick(tick)
    );

    assign addrAccept = hsel && htrans[1] && hready;
    assign next_usCount = usCount + {{(`OWB_TICK_W-1){1'b0}}, 1'b1};
    assign slotBusy = ~state[0];
    assign wrCtrl = wrPend && regHit(dataAddr, `OWB_ADDR_CTRL);
    assign wrDiv = wrPend && regHit(dataAddr, `OWB_ADDR_DIV);
    assign lowDone = tick && (next_usCount == slotLow(kind));
    assign sampleHit = tick && (kind != KIND_WZ) && (next_usCount == slotSample(kind));
    assign slotDone = tick && (next_usCount == slotTotal(kind));

    // next-state decode; the datapath flops below follow the same phases
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (startSlot)
                begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (lowDone)
                begin
                    next_state = ST_REL;
                end
            end
            ST_REL:
            begin
                if (slotDone)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // decode of a command write; only honoured while no slot runs
    always @*
    begin
        startSlot = 1'b0;
        startKind = KIND_PRES;
        if (wrCtrl && (state == ST_IDLE))
        begin
            if (hwdata[`OWB_CTRL_WZ_BIT])
            begin
                startSlot = 1'b1;
                startKind = KIND_WZ;
            end
            else if (hwdata[`OWB_CTRL_WOR_BIT])
            begin
                startSlot = 1'b1;
                startKind = KIND_WOR;
            end
            else if (hwdata[`OWB_CTRL_PRES_BIT])
            begin
                startSlot = 1'b1;
                startKind = KIND_PRES;
            end
        end
    end

    // read mux; settles during the wait state so hrdata can be a flop
    always @*
    begin
        next_rdata = 32'h00000000;
        case (dataAddr)
            `OWB_ADDR_CTRL:
            begin
                next_rdata[`OWB_CTRL_PRES_BIT] = presenceCmd;
                next_rdata[`OWB_CTRL_WZ_BIT] = writeZeroCmd;
                next_rdata[`OWB_CTRL_WOR_BIT] = writeOneReadCmd;
            end
            `OWB_ADDR_STATUS:
            begin
                next_rdata[`OWB_STAT_PRES_BIT] = presenceFlag;
                next_rdata[`OWB_STAT_RD_BIT] = readResultBit;
                next_rdata[`OWB_STAT_BUSY_BIT] = slotBusy;
            end
            `OWB_ADDR_DIV:
            begin
                next_rdata = {{(32-`OWB_DIV_W){1'b0}}, divisor};
            end
            default:
            begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // bus slave: writes take no wait state, reads take one so that a
    // read right after a write sees the written value
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            dataAddr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end
        else
        begin
            hresp <= 1'b0;
            wrPend <= 1'b0;
            if (rdPend)
            begin
                rdPend <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= next_rdata;
            end
            else if (addrAccept)
            begin
                dataAddr <= {haddr[11:2], 2'b00};
                if (hwrite)
                begin
                    wrPend <= 1'b1;
                end
                else
                begin
                    rdPend <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // divider register; a change only alters later ticks
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            divisor <= `OWB_DIV_RESET;
        end
        else if (wrDiv)
        begin
            divisor <= hwdata[`OWB_DIV_W-1:0];
        end
    end

    // slot sequencer
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            kind <= KIND_PRES;
            usCount <= {`OWB_TICK_W{1'b0}};
            presenceCmd <= 1'b0;
            writeZeroCmd <= 1'b0;
            writeOneReadCmd <= 1'b0;
            presenceFlag <= `OWB_PRES_RESET;
            readResultBit <= `OWB_RD_RESET;
            sampleVal <= 1'b1;
            singleWirePinOut <= 1'b0;
            singleWirePinOe <= 1'b0;
        end
        else
        begin
            // pin output is a constant low; only the enable moves
            singleWirePinOut <= 1'b0;
            state <= next_state;
            case (state)
                ST_IDLE:
                begin
                    singleWirePinOe <= 1'b0;
                    if (startSlot)
                    begin
                        kind <= startKind;
                        usCount <= {`OWB_TICK_W{1'b0}};
                        sampleVal <= 1'b1;
                        singleWirePinOe <= 1'b1;
                        presenceCmd <= (startKind == KIND_PRES);
                        writeZeroCmd <= (startKind == KIND_WZ);
                        writeOneReadCmd <= (startKind == KIND_WOR);
                    end
                end
                ST_LOW:
                begin
                    singleWirePinOe <= 1'b1;
                    if (tick)
                    begin
                        usCount <= next_usCount;
                        if (lowDone)
                        begin
                            // released, never driven high
                            singleWirePinOe <= 1'b0;
                        end
                    end
                end
                ST_REL:
                begin
                    singleWirePinOe <= 1'b0;
                    if (tick)
                    begin
                        usCount <= next_usCount;
                        // slave may hold the line low here
                        if (sampleHit)
                        begin
                            sampleVal <= singleWirePinIn;
                        end
                        if (slotDone)
                        begin
                            presenceCmd <= 1'b0;
                            writeZeroCmd <= 1'b0;
                            writeOneReadCmd <= 1'b0;
                            if (kind == KIND_WOR)
                            begin
                                readResultBit <= sampleVal;
                            end
                            if (kind == KIND_PRES)
                            begin
                                // a low answer means a slave is there
                                presenceFlag <= ~sampleVal;
                            end
                        end
                    end
                end
                default:
                begin
                    singleWirePinOe <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** hdl/owb_tick_gen.v ***
`timescale 1ns/1ps
`include "owb_consts.vh"

// one-microsecond tick; restart realigns the phase so the first tick
// lands exactly one microsecond after a slot begins
module owb_tick_gen
(
    input wire core_clk,
    input wire rst_n,
    input wire restart,
    input wire [`OWB_DIV_W-1:0] divisor,
    output reg tick
);

    reg [`OWB_DIV_W-1:0] divCount;

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            divCount <= {`OWB_DIV_W{1'b0}};
            tick <= 1'b0;
        end
        else if (restart)
        begin
            divCount <= {`OWB_DIV_W{1'b0}};
            tick <= 1'b0;
        end
        else if (divCount >= divisor)
        begin
            divCount <= {`OWB_DIV_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            divCount <= divCount + {{(`OWB_DIV_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end

endmodule

// *** shared/owb_consts.vh ***
`ifndef OWB_CONSTS_VH
`define OWB_CONSTS_VH

// clock and timebase
`define OWB_CLK_MHZ 40
`define OWB_DIV_W 8
`define OWB_DIV_RESET 8'd39

// register byte addresses
`define OWB_ADDR_CTRL 12'h000
`define OWB_ADDR_STATUS 12'h004
`define OWB_ADDR_DIV 12'h008

// control register fields
`define OWB_CTRL_PRES_BIT 0
`define OWB_CTRL_WZ_BIT 1
`define OWB_CTRL_WOR_BIT 2

// status register fields
`define OWB_STAT_PRES_BIT 0
`define OWB_STAT_RD_BIT 1
`define OWB_STAT_BUSY_BIT 2

// reset values
`define OWB_PRES_RESET 1'b0
`define OWB_RD_RESET 1'b0

// slot timing, in microsecond ticks
`define OWB_TICK_W 10
`define OWB_WZ_TOTAL_US 10'd117
`define OWB_WZ_LOW_US 10'd100
`define OWB_WOR_TOTAL_US 10'd70
`define OWB_WOR_LOW_US 10'd6
`define OWB_WOR_SAMPLE_US 10'd15
`define OWB_PRES_TOTAL_US 10'd960
`define OWB_PRES_LOW_US 10'd480
`define OWB_PRES_SAMPLE_US 10'd550

`endif
